// file: src/cpuamd_regs.svh
// Constants of the operand addressing decoder
`ifndef CPUAMD_REGS_SVH
`define CPUAMD_REGS_SVH

`define CPUAMD_PAGE0_HI    8'h00
`define CPUAMD_MASK_LVL3   2'h3
`define CPUAMD_MASK_LVL0   2'h0
`define CPUAMD_MASK_RESET  2'h3
`define CPUAMD_ADDR_RESET  16'h0000
`define CPUAMD_IDX_S_MAX   16'h01fe

`endif

// file: src/cpuamd_pkg.sv
// Types of the operand addressing decoder
package cpuamd_pkg;

	// ----------------------------------------------------------------
	// Addressing modes
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		AM_INH   = 5'h00,
		AM_IMM   = 5'h01,
		AM_DIR_S = 5'h02,
		AM_DIR_L = 5'h03,
		AM_IDX_0 = 5'h04,
		AM_IDX_S = 5'h05,
		AM_IDX_L = 5'h06,
		AM_IND_S = 5'h07,
		AM_IND_L = 5'h08,
		AM_IIX_S = 5'h09,
		AM_IIX_L = 5'h0a,
		AM_REL_D = 5'h0b,
		AM_REL_I = 5'h0c,
		AM_BIT_D = 5'h0d,
		AM_BIT_I = 5'h0e,
		AM_BTR_D = 5'h0f,
		AM_BTR_I = 5'h10
	} cpuamd_mode_t;

	typedef enum logic [2:0] {
		FAM_INHERENT  = 3'h0,
		FAM_IMMEDIATE = 3'h1,
		FAM_DIRECT    = 3'h2,
		FAM_INDEXED   = 3'h3,
		FAM_INDIRECT  = 3'h4,
		FAM_RELATIVE  = 3'h5,
		FAM_BIT       = 3'h6
	} cpuamd_family_t;

	// Where the address base comes from
	typedef enum logic [2:0] {
		SRC_NONE = 3'h0,
		SRC_OPB  = 3'h1,
		SRC_OPW  = 3'h2,
		SRC_OPH  = 3'h3,
		SRC_PTB  = 3'h4,
		SRC_PTW  = 3'h5,
		SRC_PC1  = 3'h6
	} cpuamd_src_t;

	typedef enum logic [1:0] {
		DSP_NONE = 2'h0,
		DSP_OPB  = 2'h1,
		DSP_PTB  = 2'h2
	} cpuamd_dsp_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_OPER = 2'h1,
		ST_PTR  = 2'h2,
		ST_CALC = 2'h3
	} cpuamd_state_t;

	// Page-zero address from one byte
	function automatic logic [15:0] pz(input logic [7:0] b);
		pz = {8'h00, b};
	endfunction : pz

endpackage : cpuamd_pkg

// file: src/cpuamd_info_if.sv
// Mode attributes passed from the mode table to the sequencer
`timescale 1ns/10ps
interface cpuamd_info_if;
	cpuamd_pkg::cpuamd_mode_t   mode;
	logic [1:0]                 nbytes;
	logic [1:0]                 nptr;
	cpuamd_pkg::cpuamd_src_t    src;
	cpuamd_pkg::cpuamd_dsp_t    dsp;
	cpuamd_pkg::cpuamd_family_t family;
	logic                       use_idx;
	logic                       short_sum;
	logic                       is_long;
	logic                       ptr_hi;

	modport table_side (input mode, output nbytes, nptr, src, dsp, family,
		use_idx, short_sum, is_long, ptr_hi);
	modport seq_side (output mode, input nbytes, nptr, src, dsp, family,
		use_idx, short_sum, is_long, ptr_hi);
endinterface : cpuamd_info_if

// file: src/cpuamd_mode_table.sv
// Attribute table of the seventeen addressing modes
`timescale 1ns/10ps
module cpuamd_mode_table (
	// Mode in, attributes out
	cpuamd_info_if.table_side info
);
	always_comb
	begin
		info.nbytes    = 2'h1;
		info.nptr      = 2'h0;
		info.src       = cpuamd_pkg::SRC_OPB;
		info.dsp       = cpuamd_pkg::DSP_NONE;
		info.family    = cpuamd_pkg::FAM_DIRECT;
		info.use_idx   = 1'b0;
		info.short_sum = 1'b0;
		info.is_long   = 1'b0;
		info.ptr_hi    = 1'b0;
		case (info.mode)
			cpuamd_pkg::AM_INH:
			begin
				info.nbytes = 2'h0;
				info.src    = cpuamd_pkg::SRC_NONE;
				info.family = cpuamd_pkg::FAM_INHERENT;
			end
			cpuamd_pkg::AM_IMM:
			begin
				info.src    = cpuamd_pkg::SRC_PC1;
				info.family = cpuamd_pkg::FAM_IMMEDIATE;
			end
			cpuamd_pkg::AM_DIR_S: info.src = cpuamd_pkg::SRC_OPB;
			cpuamd_pkg::AM_DIR_L:
			begin
				info.nbytes  = 2'h2;
				info.src     = cpuamd_pkg::SRC_OPW;
				info.is_long = 1'b1;
			end
			cpuamd_pkg::AM_IDX_0:
			begin
				info.nbytes    = 2'h0;
				info.src       = cpuamd_pkg::SRC_NONE;
				info.family    = cpuamd_pkg::FAM_INDEXED;
				info.use_idx   = 1'b1;
				info.short_sum = 1'b1;
			end
			cpuamd_pkg::AM_IDX_S:
			begin
				info.family    = cpuamd_pkg::FAM_INDEXED;
				info.use_idx   = 1'b1;
				info.short_sum = 1'b1;
			end
			cpuamd_pkg::AM_IDX_L:
			begin
				info.nbytes  = 2'h2;
				info.src     = cpuamd_pkg::SRC_OPW;
				info.family  = cpuamd_pkg::FAM_INDEXED;
				info.use_idx = 1'b1;
				info.is_long = 1'b1;
			end
			cpuamd_pkg::AM_IND_S:
			begin
				info.nptr   = 2'h1;
				info.src    = cpuamd_pkg::SRC_PTB;
				info.family = cpuamd_pkg::FAM_INDIRECT;
			end
			cpuamd_pkg::AM_IND_L:
			begin
				info.nptr    = 2'h2;
				info.src     = cpuamd_pkg::SRC_PTW;
				info.family  = cpuamd_pkg::FAM_INDIRECT;
				info.is_long = 1'b1;
			end
			cpuamd_pkg::AM_IIX_S:
			begin
				info.nptr      = 2'h1;
				info.src       = cpuamd_pkg::SRC_PTB;
				info.family    = cpuamd_pkg::FAM_INDIRECT;
				info.use_idx   = 1'b1;
				info.short_sum = 1'b1;
			end
			cpuamd_pkg::AM_IIX_L:
			begin
				info.nptr    = 2'h2;
				info.src     = cpuamd_pkg::SRC_PTW;
				info.family  = cpuamd_pkg::FAM_INDIRECT;
				info.use_idx = 1'b1;
				info.is_long = 1'b1;
			end
			cpuamd_pkg::AM_REL_D:
			begin
				info.src    = cpuamd_pkg::SRC_NONE;
				info.dsp    = cpuamd_pkg::DSP_OPB;
				info.family = cpuamd_pkg::FAM_RELATIVE;
			end
			cpuamd_pkg::AM_REL_I:
			begin
				info.nptr   = 2'h1;
				info.src    = cpuamd_pkg::SRC_NONE;
				info.dsp    = cpuamd_pkg::DSP_PTB;
				info.family = cpuamd_pkg::FAM_RELATIVE;
			end
			cpuamd_pkg::AM_BIT_D: info.family = cpuamd_pkg::FAM_BIT;
			cpuamd_pkg::AM_BIT_I:
			begin
				info.nptr   = 2'h1;
				info.src    = cpuamd_pkg::SRC_PTB;
				info.family = cpuamd_pkg::FAM_BIT;
			end
			cpuamd_pkg::AM_BTR_D:
			begin
				info.nbytes = 2'h2;
				info.src    = cpuamd_pkg::SRC_OPH;
				info.dsp    = cpuamd_pkg::DSP_OPB;
				info.family = cpuamd_pkg::FAM_BIT;
			end
			cpuamd_pkg::AM_BTR_I:
			begin
				info.nbytes = 2'h2;
				info.nptr   = 2'h1;
				info.src    = cpuamd_pkg::SRC_PTB;
				info.dsp    = cpuamd_pkg::DSP_OPB;
				info.family = cpuamd_pkg::FAM_BIT;
				info.ptr_hi = 1'b1;
			end
			default:
			begin
				info.nbytes = 2'h0;
				info.src    = cpuamd_pkg::SRC_NONE;
				info.family = cpuamd_pkg::FAM_INHERENT;
			end
		endcase
	end

endmodule : cpuamd_mode_table

// file: src/cpuamd_ea_calc.sv
// Effective address and branch target adders
`timescale 1ns/10ps
module cpuamd_ea_calc (
	// Address operands
	input  wire logic [15:0] base,
	input  wire logic [7:0]  idx,
	input  wire logic        use_idx,
	input  wire logic        short_sum,
	// Relative operands
	input  wire logic [7:0]  disp,
	input  wire logic        use_disp,
	input  wire logic [15:0] pc_next,
	// Results
	output logic      [15:0] ea,
	output logic      [15:0] target
);
	wire [8:0]  short_ea = {1'b0, base[7:0]} + {1'b0, idx};
	wire [15:0] long_ea  = base + {8'h00, idx};
	wire [15:0] disp_sx  = {{8{disp[7]}}, disp};

	// Short sums keep the carry as bit 8
	assign ea     = !use_idx ? base :
		short_sum ? {7'h00, short_ea} : long_ea;
	assign target = use_disp ? pc_next + disp_sx : pc_next;

endmodule : cpuamd_ea_calc

// file: src/cpuamd_decode.sv
// Operand addressing sequencer: operand fetch, pointer fetch, address forming
`timescale 1ns/10ps
`include "cpuamd_regs.svh"
module cpuamd_decode (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     rstn,
	// Decode request
	input  wire logic                     req_valid,
	output logic                          req_ready,
	input  wire cpuamd_pkg::cpuamd_mode_t req_mode,
	input  wire logic                     req_rmw,
	input  wire logic                     req_idx_y,
	input  wire logic [15:0]              req_pc,
	// Index registers
	input  wire logic [7:0]               x_reg,
	input  wire logic [7:0]               y_reg,
	// Interrupt mask instructions
	input  wire logic                     mask_set_instr,
	input  wire logic                     mask_clear_instr,
	output logic      [1:0]               imask_q,
	// Memory read port
	output logic                          mem_req,
	output logic      [15:0]              mem_addr_q,
	input  wire logic [7:0]               mem_rdata,
	input  wire logic                     mem_ack,
	// Results
	output logic                          done_q,
	output logic                          refused_q,
	output logic      [15:0]              ea_q,
	output logic      [7:0]               operand_q,
	output logic      [15:0]              target_q,
	output logic      [2:0]               instr_len_q,
	output cpuamd_pkg::cpuamd_family_t    family_q
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	cpuamd_pkg::cpuamd_state_t state_q, state_d;
	cpuamd_pkg::cpuamd_mode_t  mode_q;
	logic [7:0]                idx_q;
	logic [15:0]               pc_q;
	logic [15:0]               opw_q;
	logic [15:0]               ptr_q;
	logic [1:0]                cnt_q;
	logic [1:0]                pcnt_q;

	cpuamd_info_if info ();

	// ------------------------------------------------------------
	// Mode attributes
	// ------------------------------------------------------------
	wire idle = (state_q == cpuamd_pkg::ST_IDLE);
	assign info.mode = idle ? req_mode : mode_q;

	cpuamd_mode_table u_table (
		.info (info)
	);

	wire        rmw_bad   = req_rmw && info.is_long;
	wire        accept    = idle && req_valid && !rmw_bad;
	wire        refuse    = idle && req_valid && rmw_bad;
	wire        take      = (state_q == cpuamd_pkg::ST_OPER) && mem_ack;
	wire        ptake     = (state_q == cpuamd_pkg::ST_PTR) && mem_ack;
	wire [1:0]  cnt_nx    = cnt_q + 2'h1;
	wire [1:0]  pcnt_nx   = pcnt_q + 2'h1;
	wire        oper_last = take && (cnt_nx == info.nbytes);
	wire        ptr_last  = ptake && (pcnt_nx == info.nptr);
	// Pointer address: first operand byte for bit-relative, else the last one
	wire [7:0]  ptr_addr  = info.ptr_hi ? opw_q[7:0] : mem_rdata;
	wire [2:0]  len       = {1'b0, info.nbytes} + 3'h1;

	assign req_ready = idle;
	assign mem_req   = (state_q == cpuamd_pkg::ST_OPER) || (state_q == cpuamd_pkg::ST_PTR);

	// ------------------------------------------------------------
	// Address forming
	// ------------------------------------------------------------
	logic [15:0] base;
	logic [7:0]  disp;
	logic [15:0] ea_w;
	logic [15:0] target_w;

	always_comb
	begin
		case (info.src)
			cpuamd_pkg::SRC_OPB: base = cpuamd_pkg::pz(opw_q[7:0]);
			cpuamd_pkg::SRC_OPW: base = opw_q;
			cpuamd_pkg::SRC_OPH: base = cpuamd_pkg::pz(opw_q[15:8]);
			cpuamd_pkg::SRC_PTB: base = cpuamd_pkg::pz(ptr_q[7:0]);
			cpuamd_pkg::SRC_PTW: base = ptr_q;
			cpuamd_pkg::SRC_PC1: base = pc_q + 16'h0001;
			default:             base = `CPUAMD_ADDR_RESET;
		endcase
	end

	assign disp = (info.dsp == cpuamd_pkg::DSP_PTB) ? ptr_q[7:0] : opw_q[7:0];

	cpuamd_ea_calc u_calc (
		.base      (base),
		.idx       (idx_q),
		.use_idx   (info.use_idx),
		.short_sum (info.short_sum),
		.disp      (disp),
		.use_disp  (info.dsp != cpuamd_pkg::DSP_NONE),
		.pc_next   (pc_q + {13'h0000, len}),
		.ea        (ea_w),
		.target    (target_w)
	);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			cpuamd_pkg::ST_IDLE:
				if (accept)
					state_d = (info.nbytes == 2'h0) ? cpuamd_pkg::ST_CALC
						: cpuamd_pkg::ST_OPER;
			cpuamd_pkg::ST_OPER:
				if (oper_last)
					state_d = (info.nptr != 2'h0) ? cpuamd_pkg::ST_PTR
						: cpuamd_pkg::ST_CALC;
			cpuamd_pkg::ST_PTR:
				if (ptr_last)
					state_d = cpuamd_pkg::ST_CALC;
			cpuamd_pkg::ST_CALC:
				state_d = cpuamd_pkg::ST_IDLE;
			default:
				state_d = cpuamd_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= cpuamd_pkg::ST_IDLE;
			mode_q  <= cpuamd_pkg::AM_INH;
			idx_q   <= 8'h00;
			pc_q    <= `CPUAMD_ADDR_RESET;
		end
		else
		begin
			state_q <= state_d;
			if (accept)
			begin
				mode_q <= req_mode;
				idx_q  <= req_idx_y ? y_reg : x_reg;
				pc_q   <= req_pc;
			end
		end
	end

	// Byte counters and gathered words, high byte first
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_q  <= 2'h0;
			pcnt_q <= 2'h0;
			opw_q  <= 16'h0000;
			ptr_q  <= 16'h0000;
		end
		else
		begin
			if (accept)
			begin
				cnt_q  <= 2'h0;
				pcnt_q <= 2'h0;
			end
			if (take)
			begin
				cnt_q <= cnt_nx;
				opw_q <= {opw_q[7:0], mem_rdata};
			end
			if (ptake)
			begin
				pcnt_q <= pcnt_nx;
				ptr_q  <= {ptr_q[7:0], mem_rdata};
			end
		end
	end

	// Memory address: operand bytes follow the opcode, pointer bytes in page zero
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			mem_addr_q <= `CPUAMD_ADDR_RESET;
		else if (accept)
			mem_addr_q <= req_pc + 16'h0001;
		else if (take && oper_last)
			mem_addr_q <= cpuamd_pkg::pz(ptr_addr);
		else if (take)
			mem_addr_q <= mem_addr_q + 16'h0001;
		else if (ptake)
			mem_addr_q <= cpuamd_pkg::pz(mem_addr_q[7:0] + 8'h01);
	end

	// ------------------------------------------------------------
	// Results
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			done_q      <= 1'b0;
			refused_q   <= 1'b0;
			ea_q        <= `CPUAMD_ADDR_RESET;
			operand_q   <= 8'h00;
			target_q    <= `CPUAMD_ADDR_RESET;
			instr_len_q <= 3'h0;
			family_q    <= cpuamd_pkg::FAM_INHERENT;
		end
		else
		begin
			done_q    <= (state_q == cpuamd_pkg::ST_CALC);
			refused_q <= refuse;
			if (state_q == cpuamd_pkg::ST_CALC)
			begin
				ea_q        <= ea_w;
				operand_q   <= opw_q[7:0];
				target_q    <= target_w;
				instr_len_q <= len;
				family_q    <= info.family;
			end
		end
	end

	// Mask-set has priority when both arrive together
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			imask_q <= `CPUAMD_MASK_RESET;
		else if (mask_set_instr)
			imask_q <= `CPUAMD_MASK_LVL3;
		else if (mask_clear_instr)
			imask_q <= `CPUAMD_MASK_LVL0;
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_inh_no_fetch: assert property (
		accept && req_mode == cpuamd_pkg::AM_INH |-> ##1 !mem_req ##1 done_q && instr_len_q == 3'h1)
		else $error("inherent request fetched bytes or had wrong length");
	a_imm_length: assert property (
		done_q && mode_q == cpuamd_pkg::AM_IMM |-> instr_len_q == 3'h2 && ea_q == pc_q + 16'h0001)
		else $error("immediate length or operand address wrong");
	a_dir_short_page: assert property (
		done_q && mode_q == cpuamd_pkg::AM_DIR_S |-> ea_q == cpuamd_pkg::pz(opw_q[7:0]))
		else $error("short direct address not in page zero");
	a_dir_long_word: assert property (
		done_q && mode_q == cpuamd_pkg::AM_DIR_L |-> ea_q == opw_q && instr_len_q == 3'h3)
		else $error("long direct address wrong");
	a_idx_zero_value: assert property (
		done_q && mode_q == cpuamd_pkg::AM_IDX_0 |-> ea_q == cpuamd_pkg::pz(idx_q))
		else $error("no-offset indexed address wrong");
	a_idx_short_carry: assert property (
		done_q && mode_q == cpuamd_pkg::AM_IDX_S
		|-> ea_q == {7'h00, {1'b0, opw_q[7:0]} + {1'b0, idx_q}} && ea_q <= `CPUAMD_IDX_S_MAX)
		else $error("short indexed sum wrong");
	a_idx_long_sum: assert property (
		done_q && mode_q == cpuamd_pkg::AM_IDX_L |-> ea_q == opw_q + {8'h00, idx_q})
		else $error("long indexed sum wrong");
	a_ptr_page_zero: assert property (
		state_q == cpuamd_pkg::ST_PTR |-> mem_addr_q[15:8] == `CPUAMD_PAGE0_HI)
		else $error("pointer read outside page zero");
	a_ind_long_ptr: assert property (
		done_q && mode_q == cpuamd_pkg::AM_IND_L |-> ea_q == ptr_q && instr_len_q == 3'h2)
		else $error("long indirect address wrong");
	a_iix_long_sum: assert property (
		done_q && mode_q == cpuamd_pkg::AM_IIX_L |-> ea_q == ptr_q + {8'h00, idx_q})
		else $error("indirect indexed sum wrong");
	a_rel_direct_target: assert property (
		done_q && mode_q == cpuamd_pkg::AM_REL_D
		|-> target_q == pc_q + 16'h0002 + {{8{opw_q[7]}}, opw_q[7:0]})
		else $error("relative target wrong");
	a_rmw_long_refused: assert property (
		refuse |=> refused_q && idle ##1 !done_q)
		else $error("long variant accepted for read-modify-write");
	a_byte_msb_first: assert property (
		take |=> opw_q == {$past(opw_q[7:0]), $past(mem_rdata)})
		else $error("operand word assembled in wrong order");
	a_mask_set_level: assert property (
		mask_set_instr |=> imask_q == `CPUAMD_MASK_LVL3)
		else $error("mask not raised to level 3");
	a_mask_clear_level: assert property (
		mask_clear_instr && !mask_set_instr |=> imask_q == `CPUAMD_MASK_LVL0)
		else $error("mask not lowered to level 0");

	c_long_indirect: cover property (done_q && mode_q == cpuamd_pkg::AM_IIX_L);
	c_bit_relative: cover property (done_q && mode_q == cpuamd_pkg::AM_BTR_I);
	c_refused: cover property (refused_q);
	c_short_carry: cover property (done_q && mode_q == cpuamd_pkg::AM_IDX_S && ea_q[8]);

endmodule : cpuamd_decode

// file: tb/cpuamd_mem_model.sv
// Program and data memory behind the operand fetch port
`timescale 1ns/10ps
module cpuamd_mem_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// Read port
	input  wire logic        mem_req,
	input  wire logic [15:0] mem_addr,
	output logic      [7:0]  mem_rdata,
	output logic             mem_ack,
	// Behaviour controls
	input  wire logic [1:0]  slow,
	input  wire logic [7:0]  salt,
	input  wire logic        flat
);
	logic [1:0] wait_q;
	logic [7:0] last_q;
	int         rd_count;

	// ----------------------------------------------------------------
	// Contents
	// ----------------------------------------------------------------
	function automatic logic [7:0] peek(input logic [15:0] a);
		peek = flat ? 8'hff : a[7:0] ^ {a[11:8], a[15:12]} + salt;
	endfunction : peek

	// ----------------------------------------------------------------
	// Answer
	// ----------------------------------------------------------------
	assign mem_ack   = mem_req && (wait_q >= slow);
	// Idle data is the inverse of the last byte so stale samples stand out
	assign mem_rdata = mem_ack ? peek(mem_addr) : ~last_q;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wait_q   <= 2'h0;
			last_q   <= 8'h00;
			rd_count <= 0;
		end
		else
		begin
			wait_q <= (!mem_req || mem_ack) ? 2'h0 : wait_q + 2'h1;
			if (mem_ack)
			begin
				last_q   <= mem_rdata;
				rd_count <= rd_count + 1;
			end
		end
	end
endmodule : cpuamd_mem_model

// file: tb/cpuamd_decode_bench.sv
// Self-checking bench of the operand addressing decoder
`timescale 1ns/10ps
module cpuamd_decode_bench;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic                       clk;
	logic                       rstn;
	logic                       req_valid, req_ready, req_rmw, req_idx_y;
	cpuamd_pkg::cpuamd_mode_t   req_mode;
	logic [15:0]                req_pc, mem_addr_q, ea_q, target_q;
	logic [7:0]                 x_reg, y_reg, mem_rdata, operand_q, salt;
	logic                       mask_set_instr, mask_clear_instr;
	logic [1:0]                 imask_q, slow;
	logic                       mem_req, mem_ack, done_q, refused_q, flat;
	logic [2:0]                 instr_len_q;
	cpuamd_pkg::cpuamd_family_t family_q;
	int                         fail_count, compares, seed, cycles = 0;
	int                         e_len, e_rd, e_fam, e_ea, e_tgt, e_opr;
	int                         len_t[17] = '{1,2,2,3,1,2,3,2,2,2,2,2,2,2,2,3,3};
	int                         rd_t[17]  = '{0,1,1,2,0,1,2,2,3,2,3,1,2,1,2,2,3};
	int                         fam_t[17] = '{0,1,2,2,3,3,3,4,4,4,4,5,5,6,6,6,6};

	cpuamd_decode u_dut (.clk, .rstn, .req_valid, .req_ready, .req_mode, .req_rmw,
		.req_idx_y, .req_pc, .x_reg, .y_reg, .mask_set_instr, .mask_clear_instr,
		.imask_q, .mem_req, .mem_addr_q, .mem_rdata, .mem_ack, .done_q, .refused_q,
		.ea_q, .operand_q, .target_q, .instr_len_q, .family_q);
	cpuamd_mem_model u_mem (.clk, .rstn, .mem_req, .mem_addr(mem_addr_q), .mem_rdata,
		.mem_ack, .slow, .salt, .flat);

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// Reference model and helpers
	// ----------------------------------------------------------------
	function automatic int m(input int a);
		m = int'(u_mem.peek(16'(a)));
	endfunction : m

	task automatic calc(input int md, input int pc, input int ix);
		int b1, b2, w, d;
		b1 = m(pc + 1);
		b2 = m(pc + 2);
		w = m(b1) * 256 + m((b1 + 1) % 256);
		d = -1;
		e_len = len_t[md];
		e_rd = rd_t[md];
		e_fam = fam_t[md];
		e_opr = b1;
		e_ea = -1;
		case (md)
			1: e_ea = pc + 1;
			2, 13, 15: e_ea = b1;
			3: e_ea = b1 * 256 + b2;
			4: e_ea = ix;
			5: e_ea = b1 + ix;
			6: e_ea = b1 * 256 + b2 + ix;
			7, 14, 16: e_ea = m(b1);
			8: e_ea = w;
			9: e_ea = m(b1) + ix;
			10: e_ea = w + ix;
			default: ;
		endcase
		case (md)
			11: d = b1;
			12: d = m(b1);
			15, 16: d = b2;
			default: ;
		endcase
		if (e_ea >= 0)
			e_ea = e_ea & 65535;
		e_tgt = (pc + e_len + ((d > 127) ? d - 256 : ((d < 0) ? 0 : d))) & 65535;
	endtask : calc

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic end_sim();
		if (fail_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	task automatic do_reset();
		@(posedge clk);
		rstn <= 1'b0;
		repeat (5) @(posedge clk);
		@(negedge clk);
		chk("req_ready", 16'h0001, 16'(req_ready));
		chk("mem_req", 16'h0000, 16'(mem_req));
		chk("done_q", 16'h0000, 16'(done_q));
		chk("imask_q", 16'h0003, 16'(imask_q));
		@(posedge clk);
		rstn <= 1'b1;
	endtask : do_reset

	task automatic mask(input logic s, input logic c, input logic [1:0] e);
		@(posedge clk);
		mask_set_instr <= s;
		mask_clear_instr <= c;
		@(posedge clk);
		mask_set_instr <= 1'b0;
		mask_clear_instr <= 1'b0;
		@(negedge clk);
		chk("imask_q", 16'(e), 16'(imask_q));
	endtask : mask

	// One request, result compared with the reference model
	task automatic run(input int md, input logic rmw);
		int n, rd0;
		logic [15:0] pc;
		logic [7:0] xv, yv;
		logic sel, lng;
		pc = 16'($random(seed));
		xv = flat ? 8'hff : 8'($random(seed));
		yv = flat ? 8'hff : 8'($random(seed));
		sel = 1'($random(seed));
		lng = rmw && (md == 3 || md == 6 || md == 8 || md == 10);
		@(posedge clk);
		req_valid <= 1'b1;
		req_mode <= cpuamd_pkg::cpuamd_mode_t'(md);
		req_rmw <= rmw;
		req_pc <= pc;
		x_reg <= xv;
		y_reg <= yv;
		req_idx_y <= sel;
		slow <= 2'($random(seed));
		calc(md, int'(pc), int'(sel ? yv : xv));
		rd0 = u_mem.rd_count;
		@(posedge clk);
		req_valid <= 1'b0;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (n < 40 && done_q !== 1'b1 && refused_q !== 1'b1);
		if (lng)
		begin
			chk("refused_q", 16'h0001, 16'(refused_q));
			chk("fetches", 16'h0000, 16'(u_mem.rd_count - rd0));
		end
		else
		begin
			chk("done_q", 16'h0001, 16'(done_q));
			chk("instr_len_q", 16'(e_len), 16'(instr_len_q));
			chk("family_q", 16'(e_fam), 16'(family_q));
			chk("fetches", 16'(e_rd), 16'(u_mem.rd_count - rd0));
			chk("target_q", 16'(e_tgt), target_q);
			if (e_ea >= 0)
				chk("ea_q", 16'(e_ea), ea_q);
			if (md == 1)
				chk("operand_q", 16'(e_opr), 16'(operand_q));
		end
	endtask : run

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		rstn = 1'b0;
		req_valid = 1'b0;
		req_mode = cpuamd_pkg::AM_INH;
		{req_rmw, req_idx_y, mask_set_instr, mask_clear_instr, flat} = 5'h00;
		{req_pc, x_reg, y_reg, salt, slow} = 42'h0;
		seed = 24415;
		fail_count = 0;
		compares = 0;
		do_reset();
		mask(1'b0, 1'b1, 2'h0);
		mask(1'b1, 1'b0, 2'h3);
		mask(1'b0, 1'b1, 2'h0);
		mask(1'b1, 1'b1, 2'h3);
		// Round 3 uses all-ones data for the carry and wrap corners
		for (int r = 0; r < 8; r++)
		begin
			@(posedge clk);
			flat <= (r == 3);
			salt <= 8'($random(seed));
			for (int md = 0; md < 17; md++)
				run(md, r == 5);
		end
		// Reset in the middle of a slow pointer fetch
		@(posedge clk);
		req_valid <= 1'b1;
		req_mode <= cpuamd_pkg::AM_BTR_I;
		slow <= 2'h3;
		@(posedge clk);
		req_valid <= 1'b0;
		// Two slow operand bytes take eight cycles; then the pointer read is pending
		repeat (9) @(posedge clk);
		do_reset();
		run(3, 1'b0);
		end_sim();
	end
endmodule : cpuamd_decode_bench
